// >>> tb_top.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import tsc_pkg::*;
    logic        i_clk, i_rst, i_wr_valid, i_auto_pump_current;
    logic [7:0]  i_wr_addr, i_wr_data, o_int_divide_low, o_lowpass_corner_code;
    logic [4:0]  i_auto_osc_band, o_ref_divide, o_osc_band_select, o_osc_band_active;
    logic [19:0] o_frac_divide, n;
    logic [1:0]  o_pump_min_pulse, o_pump_linearity;
    logic [2:0]  o_xtal_out_divide;
    logic [15:0] o_lowpass_corner_khz;
    logic        o_xtal_out_tick, o_osc_post_divide_sel, o_pump_current_source_sel;
    logic        o_pump_current_high, o_osc_autoselect_enable;
    logic        o_tune_adc_latch, o_tune_adc_read_enable;
    int          fails = 0, check_count = 0, cycles = 0;
    int          ratio[8] = '{1, 2, 2, 3, 4, 5, 7, 8};
    tsc_config_regs i_tsc_config_regs (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr),
        .i_wr_data(i_wr_data), .i_auto_osc_band(i_auto_osc_band),
        .i_auto_pump_current(i_auto_pump_current), .o_int_divide_low(o_int_divide_low),
        .o_frac_divide(o_frac_divide), .o_pump_min_pulse(o_pump_min_pulse),
        .o_pump_linearity(o_pump_linearity), .o_xtal_out_divide(o_xtal_out_divide),
        .o_xtal_out_tick(o_xtal_out_tick), .o_ref_divide(o_ref_divide),
        .o_osc_post_divide_sel(o_osc_post_divide_sel),
        .o_pump_current_source_sel(o_pump_current_source_sel),
        .o_pump_current_high(o_pump_current_high), .o_osc_band_select(o_osc_band_select),
        .o_osc_band_active(o_osc_band_active),
        .o_osc_autoselect_enable(o_osc_autoselect_enable),
        .o_tune_adc_latch(o_tune_adc_latch), .o_tune_adc_read_enable(o_tune_adc_read_enable),
        .o_lowpass_corner_code(o_lowpass_corner_code),
        .o_lowpass_corner_khz(o_lowpass_corner_khz)
    );
    tsc_host_model i_tsc_host_model (.i_clk(i_clk), .o_wr_valid(i_wr_valid),
                                     .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // two extra edges so derived outputs have landed too
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_tsc_host_model.write(a, d);
        repeat (2) @(negedge i_clk);
    endtask
    task print_verdict;
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard, well above the roughly 17000 cycles the run needs
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_auto_osc_band = 5'h11;
        i_auto_pump_current = 1'b0;
        repeat (5) @(negedge i_clk);
        check("int low", o_int_divide_low, 8'h23);
        check("frac", o_frac_divide, 20'd194180);
        check("xtal code", o_xtal_out_divide, 3'h0);
        check("ref div", o_ref_divide, 5'h01);
        check("post div", o_osc_post_divide_sel, 1'b1);
        check("pump src", o_pump_current_source_sel, 1'b1);
        check("band", o_osc_band_select, 5'h19);
        check("autosel", o_osc_autoselect_enable, 1'b1);
        check("adc", {o_tune_adc_latch, o_tune_adc_read_enable}, 2'b00);
        i_rst = 1'b0;
        i_tsc_host_model.power_up(4'hA);
        wr(ADDR_FRAC_DIVIDE_MID, 8'h5C);
        wr(ADDR_FRAC_DIVIDE_LOW, 8'hE1);
        check("frac", o_frac_divide, 20'hA5CE1);
        check("pump bits", {o_pump_min_pulse, o_pump_linearity}, 4'h1);
        wr(ADDR_INT_DIVIDE_LOW, 8'hFB);
        wr(8'h09, 8'h55);
        wr(8'h00, 8'hAA);
        check("int low", o_int_divide_low, 8'hFB);
        // manual pump level, then autoselect source at both input levels
        wr(ADDR_SYNTH_CTRL, 8'h3F);
        check("post div", o_osc_post_divide_sel, 1'b0);
        check("pump high", o_pump_current_high, 1'b1);
        wr(ADDR_SYNTH_CTRL, 8'h5F);
        check("pump high", o_pump_current_high, 1'b0);
        i_auto_pump_current = 1'b1;
        repeat (2) @(negedge i_clk);
        check("pump high", o_pump_current_high, 1'b1);
        wr(ADDR_SYNTH_CTRL, 8'h80);
        check("pump high", o_pump_current_high, 1'b0);
        // band source and converter controls in both selection modes
        wr(ADDR_OSC_SELECT_CTRL, 8'h03);
        check("band act", o_osc_band_active, 5'h00);
        check("adc", {o_tune_adc_latch, o_tune_adc_read_enable}, 2'b11);
        wr(ADDR_OSC_SELECT_CTRL, 8'h57);
        check("band act", o_osc_band_active, 5'h11);
        check("adc", {o_tune_adc_latch, o_tune_adc_read_enable}, 2'b00);
        wr(ADDR_OSC_SELECT_CTRL, 8'h52);
        check("band act", o_osc_band_active, 5'h0A);
        check("adc", {o_tune_adc_latch, o_tune_adc_read_enable}, 2'b10);
        wr(ADDR_LOWPASS_CORNER, 8'hFC);
        check("lpf code", o_lowpass_corner_code, 8'hFC);
        check("lpf khz", o_lowpass_corner_khz, 16'd4000);
        wr(ADDR_LOWPASS_CORNER, 8'h0F);
        check("lpf khz", o_lowpass_corner_khz, 16'd4870);
        // 840 cycles hold a whole number of periods for every ratio
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_XTAL_AND_REF_DIV, {c[2:0], 5'h01});
            repeat (16) @(negedge i_clk);
            n = 20'h0;
            repeat (840) begin
                @(negedge i_clk);
                n = n + 20'(o_xtal_out_tick);
            end
            check("xtal ticks", n, 20'(840 / ratio[c]));
        end
        print_verdict();
    end
endmodule
bind tsc_config_regs tsc_config_regs_monitor i_tsc_config_regs_monitor (
    .i_clk(i_clk), .i_rst(i_rst), .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .i_auto_osc_band(i_auto_osc_band),
    .i_auto_pump_current(i_auto_pump_current), .o_int_divide_low(o_int_divide_low),
    .o_frac_divide(o_frac_divide), .o_pump_current_source_sel(o_pump_current_source_sel),
    .o_pump_current_high(o_pump_current_high), .o_osc_band_select(o_osc_band_select),
    .o_osc_band_active(o_osc_band_active),
    .o_osc_autoselect_enable(o_osc_autoselect_enable),
    .o_tune_adc_latch(o_tune_adc_latch), .o_tune_adc_read_enable(o_tune_adc_read_enable),
    .o_lowpass_corner_code(o_lowpass_corner_code),
    .o_lowpass_corner_khz(o_lowpass_corner_khz)
);
`default_nettype wire

// >>> tsc_config_regs.sv
// tuner synthesizer configuration register bank, written byte by byte
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RQ1: integer low byte stored whole; host keeps 19..251
// RQ2: host writes pump minimum pulse as 00
// RQ3: host writes pump linearity as 01
// RQ4: fraction is 20 bits, resets to 194180
// RQ5: crystal output divide code selects ratio
// RQ6: reference divide resets to one; host keeps it
// RQ7: post divide select, reset to four
// RQ8: pump current from level bit or autoselect
// RQ9: band select is manual value and autoselect start
// RQ10: autoselect enable picks band source, reset one
// RQ11: converter latch follows bit when autoselect off
// RQ12: converter read follows bit when autoselect off
// RQ13: lowpass code sets filter corner
// RQ14: integer low and fraction mid reset values
// RQ15: host waits 100 us after power up
// RQ16: unused synth bits ignored; whole bytes only
module tsc_config_regs (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // byte writes from the serial protocol engine
    input  wire logic        i_wr_valid,
    input  wire logic [7:0]  i_wr_addr,
    input  wire logic [7:0]  i_wr_data,
    // autoselect engine results
    input  wire logic [4:0]  i_auto_osc_band,
    input  wire logic        i_auto_pump_current,
    // configuration outputs
    output logic [7:0]       o_int_divide_low,
    output logic [19:0]      o_frac_divide,
    output logic [1:0]       o_pump_min_pulse,
    output logic [1:0]       o_pump_linearity,
    output logic [2:0]       o_xtal_out_divide,
    output var logic         o_xtal_out_tick,
    output logic [4:0]       o_ref_divide,
    output logic             o_osc_post_divide_sel,
    output logic             o_pump_current_source_sel,
    output logic             o_pump_current_high,
    output logic [4:0]       o_osc_band_select,
    output logic [4:0]       o_osc_band_active,
    output logic             o_osc_autoselect_enable,
    output logic             o_tune_adc_latch,
    output logic             o_tune_adc_read_enable,
    output logic [7:0]       o_lowpass_corner_code,
    output logic [15:0]      o_lowpass_corner_khz
);
    import tsc_pkg::*;

    logic [7:0] int_divide_low;
    logic [7:0] charge_pump_ctrl;
    logic [7:0] frac_divide_mid;
    logic [7:0] frac_divide_low;
    logic [7:0] xtal_and_ref_divider;
    logic [7:0] synth_ctrl;
    logic [7:0] osc_select_ctrl;
    logic [7:0] lowpass_corner;

    logic [7:0] next_int_divide_low;
    logic [7:0] next_charge_pump_ctrl;
    logic [7:0] next_frac_divide_mid;
    logic [7:0] next_frac_divide_low;
    logic [7:0] next_xtal_and_ref_divider;
    logic [7:0] next_synth_ctrl;
    logic [7:0] next_osc_select_ctrl;
    logic [7:0] next_lowpass_corner;

    logic       auto_on;
    logic       pump_high_q;
    logic [4:0] band_q;
    logic [15:0] corner_q;

    logic        next_pump_high;
    logic [4:0]  next_band;
    logic [15:0] next_corner;

    tsc_xdiv_if xdiv ();

    ////////////////////////////////////////////////////////////////////////
    // register writes: the engine strobes only after the full byte and its
    // acknowledge, so a half-shifted byte never reaches the outputs
    always_comb begin
        next_int_divide_low       = int_divide_low;
        next_charge_pump_ctrl     = charge_pump_ctrl;
        next_frac_divide_mid      = frac_divide_mid;
        next_frac_divide_low      = frac_divide_low;
        next_xtal_and_ref_divider = xtal_and_ref_divider;
        next_synth_ctrl           = synth_ctrl;
        next_osc_select_ctrl      = osc_select_ctrl;
        next_lowpass_corner       = lowpass_corner;
        if (i_wr_valid) begin                                 // see RQ16
            case (i_wr_addr)
                ADDR_INT_DIVIDE_LOW: begin
                    next_int_divide_low = i_wr_data;          // see RQ1
                end
                ADDR_CHARGE_PUMP_CTRL: begin
                    next_charge_pump_ctrl = i_wr_data;        // see RQ4
                end
                ADDR_FRAC_DIVIDE_MID: begin
                    next_frac_divide_mid = i_wr_data;
                end
                ADDR_FRAC_DIVIDE_LOW: begin
                    next_frac_divide_low = i_wr_data;
                end
                ADDR_XTAL_AND_REF_DIV: begin
                    next_xtal_and_ref_divider = i_wr_data;    // see RQ5
                end
                ADDR_SYNTH_CTRL: begin
                    // low five bits have no function and are stored as zero
                    next_synth_ctrl = i_wr_data & SYNTH_CTRL_USED_MASK; // see RQ16
                end
                ADDR_OSC_SELECT_CTRL: begin
                    next_osc_select_ctrl = i_wr_data;         // see RQ9
                end
                ADDR_LOWPASS_CORNER: begin
                    next_lowpass_corner = i_wr_data;          // see RQ13
                end
                default: begin
                    // other addresses belong to registers outside this bank
                end
            endcase
        end
    end

    // reset values load at power up
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            int_divide_low       <= RST_INT_DIVIDE_LOW;       // see RQ14
            charge_pump_ctrl     <= RST_CHARGE_PUMP_CTRL;     // see RQ4
            frac_divide_mid      <= RST_FRAC_DIVIDE_MID;      // see RQ14
            frac_divide_low      <= RST_FRAC_DIVIDE_LOW;      // see RQ4
            xtal_and_ref_divider <= RST_XTAL_AND_REF_DIV;     // see RQ5
            synth_ctrl           <= RST_SYNTH_CTRL;           // see RQ7
            osc_select_ctrl      <= RST_OSC_SELECT_CTRL;      // see RQ10
            lowpass_corner       <= RST_LOWPASS_CORNER;
        end else begin
            int_divide_low       <= next_int_divide_low;
            charge_pump_ctrl     <= next_charge_pump_ctrl;
            frac_divide_mid      <= next_frac_divide_mid;
            frac_divide_low      <= next_frac_divide_low;
            xtal_and_ref_divider <= next_xtal_and_ref_divider;
            synth_ctrl           <= next_synth_ctrl;
            osc_select_ctrl      <= next_osc_select_ctrl;
            lowpass_corner       <= next_lowpass_corner;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field views, all straight from the register flops
    assign auto_on = osc_select_ctrl[OSC_AUTOSEL_BIT];                // see RQ10

    assign o_int_divide_low  = int_divide_low;
    assign o_frac_divide     = {charge_pump_ctrl[FRAC_TOP_LSB +: 4],
                                frac_divide_mid, frac_divide_low};    // see RQ4
    // stored as written; the host owes 00 and 01 here after power up
    assign o_pump_min_pulse  = charge_pump_ctrl[PUMP_MIN_PULSE_LSB +: 2];
    assign o_pump_linearity  = charge_pump_ctrl[PUMP_LINEARITY_LSB +: 2];
    assign o_xtal_out_divide = xtal_and_ref_divider[XTAL_OUT_DIVIDE_LSB +: 3];
    assign o_ref_divide      = xtal_and_ref_divider[REF_DIVIDE_LSB +: 5];    // see RQ6
    assign o_osc_post_divide_sel     = synth_ctrl[OSC_POST_DIVIDE_BIT];      // see RQ7
    assign o_pump_current_source_sel = synth_ctrl[PUMP_SOURCE_SEL_BIT];
    assign o_osc_band_select         = osc_select_ctrl[OSC_BAND_LSB +: 5];
    assign o_osc_autoselect_enable   = auto_on;
    assign o_lowpass_corner_code     = lowpass_corner;

    ////////////////////////////////////////////////////////////////////////
    // converter controls only reach the converter in manual mode; while the
    // autoselect circuit runs it owns the converter
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_tune_adc_latch       <= 1'b0;
            o_tune_adc_read_enable <= 1'b0;
        end else begin
            o_tune_adc_latch       <= !auto_on && osc_select_ctrl[TUNE_ADC_LATCH_BIT]; // see RQ11
            o_tune_adc_read_enable <= !auto_on && osc_select_ctrl[TUNE_ADC_READ_BIT];  // see RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // effective pump current, active band and corner estimate
    always_comb begin
        if (synth_ctrl[PUMP_SOURCE_SEL_BIT]) begin
            next_pump_high = i_auto_pump_current;                    // see RQ8
        end else begin
            next_pump_high = synth_ctrl[PUMP_LEVEL_BIT];             // see RQ8
        end
        if (auto_on) begin
            next_band = i_auto_osc_band;                             // see RQ10
        end else begin
            next_band = osc_select_ctrl[OSC_BAND_LSB +: 5];          // see RQ9
        end
        // low nibble only; codes below 12 bend under the base, still positive
        next_corner = LPF_BASE_KHZ
                    + 16'(({12'h000, lowpass_corner[3:0]} * LPF_STEP_KHZ))
                    - 16'(LPF_OFFSET * LPF_STEP_KHZ);                // see RQ13
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pump_high_q <= 1'b0;
            band_q      <= 5'h00;
            corner_q    <= 16'h0000;
        end else begin
            pump_high_q <= next_pump_high;
            band_q      <= next_band;
            corner_q    <= next_corner;
        end
    end

    assign o_pump_current_high  = pump_high_q;
    assign o_osc_band_active    = band_q;
    assign o_lowpass_corner_khz = corner_q;

    ////////////////////////////////////////////////////////////////////////
    // crystal output divider
    assign xdiv.divide_code = xtal_and_ref_divider[XTAL_OUT_DIVIDE_LSB +: 3];  // see RQ5
    assign o_xtal_out_tick  = xdiv.tick;

    tsc_xtal_div u_xtal_div (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .xdiv  (xdiv.div)
    );
endmodule
`default_nettype wire

// >>> tsc_config_regs_monitor.sv
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ns
`default_nettype none
module tsc_config_regs_monitor (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_wr_valid,
    input wire logic [7:0]  i_wr_addr,
    input wire logic [7:0]  i_wr_data,
    input wire logic [4:0]  i_auto_osc_band,
    input wire logic        i_auto_pump_current,
    input wire logic [7:0]  o_int_divide_low,
    input wire logic [19:0] o_frac_divide,
    input wire logic        o_pump_current_source_sel,
    input wire logic        o_pump_current_high,
    input wire logic [4:0]  o_osc_band_select,
    input wire logic [4:0]  o_osc_band_active,
    input wire logic        o_osc_autoselect_enable,
    input wire logic        o_tune_adc_latch,
    input wire logic        o_tune_adc_read_enable,
    input wire logic [7:0]  o_lowpass_corner_code,
    input wire logic [15:0] o_lowpass_corner_khz
);
    import tsc_pkg::*;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////////////////////
    // stored bytes show one edge after the taking edge
    property p_int_low;
        i_wr_valid && i_wr_addr == ADDR_INT_DIVIDE_LOW |=> o_int_divide_low == $past(i_wr_data);
    endproperty
    a_int_low: assert property (p_int_low) else $error("integer low byte not stored");
    property p_frac_top;
        i_wr_valid && i_wr_addr == ADDR_CHARGE_PUMP_CTRL |=> o_frac_divide[19:16] == $past(i_wr_data[3:0]);
    endproperty
    a_frac_top: assert property (p_frac_top) else $error("fraction top bits wrong");
    // no write, or a write elsewhere, leaves the integer low byte alone
    property p_hold;
        !i_wr_valid || i_wr_addr != ADDR_INT_DIVIDE_LOW |=> $stable(o_int_divide_low);
    endproperty
    a_hold: assert property (p_hold) else $error("integer low byte changed unasked");
    ////////////////////////////////////////////////////////////////////////////////
    // derived outputs lag their cause by one edge; at the first edge after
    // reset they still show their reset zeros, so p_band and p_khz skip that edge
    property p_pump;
        $past(o_pump_current_source_sel) |-> o_pump_current_high == $past(i_auto_pump_current);
    endproperty
    a_pump: assert property (p_pump) else $error("pump current not from autoselect");
    property p_band;
        !$past(i_rst) |-> o_osc_band_active == ($past(o_osc_autoselect_enable)
                                                ? $past(i_auto_osc_band)
                                                : $past(o_osc_band_select));
    endproperty
    a_band: assert property (p_band) else $error("active band from wrong source");
    property p_latch;
        i_wr_valid && i_wr_addr == ADDR_OSC_SELECT_CTRL |=> ##1
            o_tune_adc_latch == (!$past(i_wr_data[2], 2) && $past(i_wr_data[1], 2));
    endproperty
    a_latch: assert property (p_latch) else $error("converter latch wrong");
    property p_read;
        o_tune_adc_read_enable |-> !$past(o_osc_autoselect_enable);
    endproperty
    a_read: assert property (p_read) else $error("converter read during autoselect");
    property p_khz;
        !$past(i_rst) |->
            o_lowpass_corner_khz == 16'(520 + 290 * $past(o_lowpass_corner_code[3:0]));
    endproperty
    a_khz: assert property (p_khz) else $error("lowpass corner wrong");
endmodule
`default_nettype wire

// >>> tsc_host_model.sv
// host controller model: byte writes and the power-up sequence
`timescale 1ns/1ns
`default_nettype none
module tsc_host_model (
    input  wire logic       i_clk,
    output logic            o_wr_valid,
    output logic [7:0]      o_wr_addr,
    output logic [7:0]      o_wr_data
);
    import tsc_pkg::*;
    localparam int POWER_UP_WAIT = 10000; // 100 us at 10 ns
    initial begin
        o_wr_valid = 1'b0;
        o_wr_addr = 8'hFF;
        o_wr_data = 8'h00;
    end
    // one byte per call; released lines flip so stale values never look valid
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_clk);
        o_wr_valid = 1'b1;
        o_wr_addr = addr;
        o_wr_data = data;
        @(negedge i_clk);
        o_wr_valid = 1'b0;
        o_wr_addr = ~o_wr_addr;
        o_wr_data = ~o_wr_data;
    endtask
    // mandatory settings after power-up, never before the settling wait
    task automatic power_up(input logic [3:0] frac_top);
        repeat (POWER_UP_WAIT) @(negedge i_clk);
        write(ADDR_CHARGE_PUMP_CTRL, {2'b00, 2'b01, frac_top});
        write(ADDR_XTAL_AND_REF_DIV, 8'h01);
    endtask
endmodule
`default_nettype wire

// >>> tsc_pkg.sv
// tuner synthesizer configuration: register offsets, fields and reset values
package tsc_pkg;
    // register byte addresses on the serial register port
    localparam logic [7:0] ADDR_INT_DIVIDE_LOW     = 8'h01;
    localparam logic [7:0] ADDR_CHARGE_PUMP_CTRL   = 8'h02;
    localparam logic [7:0] ADDR_FRAC_DIVIDE_MID    = 8'h03;
    localparam logic [7:0] ADDR_FRAC_DIVIDE_LOW    = 8'h04;
    localparam logic [7:0] ADDR_XTAL_AND_REF_DIV   = 8'h05;
    localparam logic [7:0] ADDR_SYNTH_CTRL         = 8'h06;
    localparam logic [7:0] ADDR_OSC_SELECT_CTRL    = 8'h07;
    localparam logic [7:0] ADDR_LOWPASS_CORNER     = 8'h08;

    // values after reset
    localparam logic [7:0] RST_INT_DIVIDE_LOW      = 8'h23;
    localparam logic [7:0] RST_CHARGE_PUMP_CTRL    = 8'h02;
    localparam logic [7:0] RST_FRAC_DIVIDE_MID     = 8'hF6;
    localparam logic [7:0] RST_FRAC_DIVIDE_LOW     = 8'h84;
    localparam logic [7:0] RST_XTAL_AND_REF_DIV    = 8'h01;
    localparam logic [7:0] RST_SYNTH_CTRL          = 8'hC0;
    localparam logic [7:0] RST_OSC_SELECT_CTRL     = 8'hCC;
    localparam logic [7:0] RST_LOWPASS_CORNER      = 8'h4B;

    // field positions
    localparam int PUMP_MIN_PULSE_LSB     = 6;
    localparam int PUMP_LINEARITY_LSB     = 4;
    localparam int FRAC_TOP_LSB           = 0;
    localparam int XTAL_OUT_DIVIDE_LSB    = 5;
    localparam int REF_DIVIDE_LSB         = 0;
    localparam int OSC_POST_DIVIDE_BIT    = 7;
    localparam int PUMP_SOURCE_SEL_BIT    = 6;
    localparam int PUMP_LEVEL_BIT         = 5;
    localparam logic [7:0] SYNTH_CTRL_USED_MASK = 8'hE0;
    localparam int OSC_BAND_LSB           = 3;
    localparam int OSC_AUTOSEL_BIT        = 2;
    localparam int TUNE_ADC_LATCH_BIT     = 1;
    localparam int TUNE_ADC_READ_BIT      = 0;

    // lowpass corner arithmetic, kHz
    localparam logic [15:0] LPF_BASE_KHZ  = 16'd4000;
    localparam logic [15:0] LPF_STEP_KHZ  = 16'd290;
    localparam logic [15:0] LPF_OFFSET    = 16'd12;

    // crystal output divider codes
    localparam logic [2:0] XDIV_CODE_DIV1 = 3'h0;
    localparam logic [2:0] XDIV_CODE_DIV2 = 3'h1;
    localparam logic [2:0] XDIV_CODE_GAP  = 3'h2;
    localparam logic [2:0] XDIV_RATIO_TWO = 3'h1;
endpackage

// >>> tsc_xdiv_if.sv
// carrier between the register bank and the crystal output divider
`timescale 1ns/1ns
`default_nettype none
interface tsc_xdiv_if;
    logic [2:0] divide_code;
    logic       tick;
    modport ctrl (output divide_code, input tick);
    modport div  (input divide_code, output tick);
endinterface
`default_nettype wire

// >>> tsc_xtal_div.sv
// crystal output divider: one-cycle enable pulse at the selected ratio
`timescale 1ns/1ns
`default_nettype none
module tsc_xtal_div (
    input  wire logic i_clk,
    input  wire logic i_rst,
    tsc_xdiv_if.div   xdiv
);
    import tsc_pkg::*;

    logic [2:0] count;
    logic [2:0] next_count;
    logic [2:0] last;     // ratio minus one
    logic       next_tick;

    ////////////////////////////////////////////////////////////////////////
    // code to ratio: 0->1, 1->2, 3->3, 4->4, 5->5, 6->7, 7->8
    always_comb begin
        if (xdiv.divide_code == XDIV_CODE_DIV1) begin
            last = 3'h0;                          // see RQ5
        end else if (xdiv.divide_code == XDIV_CODE_DIV2 ||
                     xdiv.divide_code == XDIV_CODE_GAP) begin
            last = XDIV_RATIO_TWO;                // unlisted code 010 runs as 2
        end else if (xdiv.divide_code == 3'h7) begin
            last = 3'h7;                          // 111 divides by 8, see RQ5
        end else if (xdiv.divide_code == 3'h6) begin
            last = 3'h6;                          // 110 divides by 7, one below 111, see RQ5
        end else begin
            last = xdiv.divide_code - 3'h1;       // 011->3, 100->4, 101->5, see RQ5
        end
    end

    // counter wraps at the ratio; a shrunk ratio restarts it cleanly
    always_comb begin
        if (count >= last) begin
            next_count = 3'h0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 3'h1;
            next_tick  = 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count     <= 3'h0;
            xdiv.tick <= 1'b0;
        end else begin
            count     <= next_count;
            xdiv.tick <= next_tick;
        end
    end
endmodule
`default_nettype wire
